/* File: ifd_decoder.sv */
// Function decoder for five programmable digital control inputs
`timescale 1ns/1ns
module ifd_decoder #(
  parameter int unsigned NUM_INPUTS = ifd_pkg::IFD_NUM_INPUTS
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [NUM_INPUTS-1:0] prog_input_pin,
  input wire logic clockwise_run_input,
  input wire logic [ifd_pkg::IFD_CODE_W*NUM_INPUTS-1:0] func_code,
  input wire logic [NUM_INPUTS-1:0] nc_polarity,
  input wire logic [1:0] jog_stop_mode,
  input wire logic mains_recovered,
  input wire logic motor_running,
  input wire logic param_write_req,
  output logic cmd_run_cw,
  output logic cmd_run_ccw,
  output logic cmd_ramp_stop,
  output logic cmd_coast,
  output logic [3:0] preset_speed_select,
  output ifd_pkg::ifd_src_t setpoint_source,
  output logic cmd_jog,
  output logic [1:0] cmd_jog_stop_mode,
  output logic dc_brake_enable,
  output logic second_param_set,
  output logic alternate_ramp,
  output logic heavy_start_mode,
  output logic fault_e12,
  output logic fault_clear,
  output logic restart_blocked,
  output logic param_write_accept,
  output logic param_write_reject
);

  localparam int unsigned CW = ifd_pkg::IFD_CODE_W;

  logic [NUM_INPUTS:0] pin_sync;
  logic [NUM_INPUTS-1:0] is_ack;
  logic [NUM_INPUTS-1:0] level;
  logic cw_level;
  logic ext_prev;
  logic ack_prev;
  logic prun_prev;
  logic three_wire_run;
  logic three_wire_ccw;
  logic next_ext_prev;
  logic next_ack_prev;
  logic next_prun_prev;
  logic next_three_wire_run;
  logic next_three_wire_ccw;
  logic next_cmd_run_cw;
  logic next_cmd_run_ccw;
  logic next_cmd_ramp_stop;
  logic next_cmd_coast;
  logic [3:0] next_preset_speed_select;
  ifd_pkg::ifd_src_t next_setpoint_source;
  logic next_cmd_jog;
  logic [1:0] next_cmd_jog_stop_mode;
  logic next_dc_brake_enable;
  logic next_second_param_set;
  logic next_alternate_ramp;
  logic next_heavy_start_mode;
  logic next_fault_e12;
  logic next_fault_clear;
  logic next_restart_blocked;
  logic next_param_write_accept;
  logic next_param_write_reject;

  // Decoded function levels
  logic act_ccw;
  logic act_jog;
  logic act_db;
  logic act_coast;
  logic act_ext;
  logic act_lock;
  logic act_wlock;
  logic act_cur;
  logic act_ack;
  logic act_prun;
  logic act_pstop;
  logic act_dir;
  logic has_three_wire;
  logic has_stop_input;
  logic [3:0] preset_bits;
  logic req_cw;
  logic req_ccw;
  logic start_req;
  logic inhibit;
  logic [2:0] settle;
  logic [2:0] next_settle;
  logic armed;

  // True when any input coded as code is active
  function automatic logic fn_active(
    input logic [CW*NUM_INPUTS-1:0] codes,
    input logic [NUM_INPUTS-1:0] lv,
    input logic [7:0] code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++)
    begin
      if (codes[i*CW +: CW] == code)
      begin
        hit = hit | lv[i];
      end
    end
    return hit;
  endfunction : fn_active

  // True when some input carries code, whatever its level
  function automatic logic fn_assigned(
    input logic [CW*NUM_INPUTS-1:0] codes,
    input logic [7:0] code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++)
    begin
      hit = hit | (codes[i*CW +: CW] == code);
    end
    return hit;
  endfunction : fn_assigned

  ifd_sync #(
    .WIDTH(NUM_INPUTS + 1)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in({clockwise_run_input, prog_input_pin}),
    .sync_out(pin_sync)
  );

  assign cw_level = pin_sync[NUM_INPUTS];

  // Reset sync reads as open, so a break contact would give a false edge;
  // edges count only once the prev flops hold real levels. A level
  // already on at reset release is therefore not taken as an edge.
  assign armed = settle[2];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_level
      // Each input decoded from its own code field
      assign is_ack[gi] =
        func_code[gi*CW +: CW] == ifd_pkg::IFD_CODE_FAULT_ACK;
      // Acknowledge ignores polarity select
      assign level[gi] = pin_sync[gi] ^ (nc_polarity[gi] & ~is_ack[gi]);
    end
  endgenerate

  // Unlisted codes match nothing here
  assign act_ccw = fn_active(func_code, level, ifd_pkg::IFD_CODE_CCW_RUN);
  assign preset_bits = {
    fn_active(func_code, level, ifd_pkg::IFD_CODE_PRESET3),
    fn_active(func_code, level, ifd_pkg::IFD_CODE_PRESET2),
    fn_active(func_code, level, ifd_pkg::IFD_CODE_PRESET1),
    fn_active(func_code, level, ifd_pkg::IFD_CODE_PRESET0)
  };
  assign act_jog = fn_active(func_code, level, ifd_pkg::IFD_CODE_JOG);
  assign act_db = fn_active(func_code, level, ifd_pkg::IFD_CODE_DC_BRAKE);
  assign act_coast = fn_active(func_code, level, ifd_pkg::IFD_CODE_COAST);
  assign act_ext = fn_active(func_code, level, ifd_pkg::IFD_CODE_EXT_FAULT);
  assign act_lock =
    fn_active(func_code, level, ifd_pkg::IFD_CODE_RESTART_LOCK);
  assign act_wlock = fn_active(func_code, level, ifd_pkg::IFD_CODE_WRITE_LOCK);
  assign act_cur = fn_active(func_code, level, ifd_pkg::IFD_CODE_CURRENT_SEL);
  assign act_ack = fn_active(func_code, level, ifd_pkg::IFD_CODE_FAULT_ACK);
  assign act_prun = fn_active(func_code, level, ifd_pkg::IFD_CODE_PULSE_RUN);
  assign act_pstop = fn_active(func_code, level, ifd_pkg::IFD_CODE_PULSE_STOP);
  assign act_dir = fn_active(func_code, level, ifd_pkg::IFD_CODE_DIR_SELECT);
  assign has_three_wire = fn_assigned(func_code, ifd_pkg::IFD_CODE_PULSE_RUN);
  assign has_stop_input = fn_assigned(func_code, ifd_pkg::IFD_CODE_PULSE_STOP);

  // Three-wire scheme replaces the two direction levels while assigned
  assign req_cw = has_three_wire ? (three_wire_run & ~three_wire_ccw)
                                 : (cw_level & ~act_ccw);
  assign req_ccw = has_three_wire ? (three_wire_run & three_wire_ccw)
                                  : (act_ccw & ~cw_level);
  assign start_req = has_three_wire ? three_wire_run
                                    : (cw_level | act_ccw);
  assign inhibit = act_coast | fault_e12 | act_ack | restart_blocked;

  always_comb
  begin
    next_ext_prev = act_ext;
    next_ack_prev = act_ack;
    next_prun_prev = act_prun;
    next_settle = {settle[1:0], 1'b1};
    // Stop input is a break contact: open means stop
    next_three_wire_run = three_wire_run;
    if (has_stop_input && !act_pstop)
    begin
      next_three_wire_run = 1'b0;
    end
    else if (act_prun && !prun_prev && armed)
    begin
      next_three_wire_run = 1'b1;
    end
    next_three_wire_ccw = act_dir;
    // Both directions requested ends in neither run
    next_cmd_run_cw = req_cw & ~inhibit;
    next_cmd_run_ccw = req_ccw & ~inhibit;
    next_cmd_coast = act_coast | fault_e12 | (act_ack & motor_running);
    next_cmd_ramp_stop = ~next_cmd_run_cw & ~next_cmd_run_ccw &
                         ~next_cmd_coast;
    next_preset_speed_select = preset_bits;
    // Presets win over analog, jog over both
    if (act_jog)
    begin
      next_setpoint_source = ifd_pkg::IFD_SRC_JOG;
    end
    else if (|preset_bits)
    begin
      next_setpoint_source = ifd_pkg::IFD_SRC_PRESET;
    end
    else if (act_cur)
    begin
      next_setpoint_source = ifd_pkg::IFD_SRC_CURRENT;
    end
    else
    begin
      next_setpoint_source = ifd_pkg::IFD_SRC_VOLTAGE;
    end
    next_cmd_jog = act_jog & start_req & ~inhibit;
    next_cmd_jog_stop_mode = jog_stop_mode;
    next_dc_brake_enable = act_db;
    next_second_param_set = fn_active(func_code, level,
                                      ifd_pkg::IFD_CODE_SECOND_SET);
    next_alternate_ramp = fn_active(func_code, level,
                                    ifd_pkg::IFD_CODE_ALT_RAMP);
    next_heavy_start_mode = fn_active(func_code, level,
      ifd_pkg::IFD_CODE_HEAVY_START);
    // New fault edge wins over acknowledge in the same cycle
    next_fault_clear = act_ack & ~ack_prev & armed;
    next_fault_e12 = fault_e12;
    if (act_ext && !ext_prev && armed)
    begin
      next_fault_e12 = 1'b1;
    end
    else if (next_fault_clear)
    begin
      next_fault_e12 = 1'b0;
    end
    // Held until the start command is withdrawn
    next_restart_blocked = (restart_blocked & start_req) |
      (mains_recovered & act_lock & start_req);
    next_param_write_accept = param_write_req & ~act_wlock;
    next_param_write_reject = param_write_req & act_wlock;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      settle <= '0;
      ext_prev <= ifd_pkg::IFD_RST_LEVEL;
      ack_prev <= ifd_pkg::IFD_RST_LEVEL;
      prun_prev <= ifd_pkg::IFD_RST_LEVEL;
      three_wire_run <= ifd_pkg::IFD_RST_LEVEL;
      three_wire_ccw <= ifd_pkg::IFD_RST_LEVEL;
      cmd_run_cw <= ifd_pkg::IFD_RST_LEVEL;
      cmd_run_ccw <= ifd_pkg::IFD_RST_LEVEL;
      cmd_ramp_stop <= 1'b1;
      cmd_coast <= ifd_pkg::IFD_RST_LEVEL;
      preset_speed_select <= ifd_pkg::IFD_RST_PRESET;
      setpoint_source <= ifd_pkg::IFD_SRC_VOLTAGE;
      cmd_jog <= ifd_pkg::IFD_RST_LEVEL;
      cmd_jog_stop_mode <= ifd_pkg::IFD_RST_JOG_MODE;
      dc_brake_enable <= ifd_pkg::IFD_RST_LEVEL;
      second_param_set <= ifd_pkg::IFD_RST_LEVEL;
      alternate_ramp <= ifd_pkg::IFD_RST_LEVEL;
      heavy_start_mode <= ifd_pkg::IFD_RST_LEVEL;
      fault_e12 <= ifd_pkg::IFD_RST_LEVEL;
      fault_clear <= ifd_pkg::IFD_RST_LEVEL;
      restart_blocked <= ifd_pkg::IFD_RST_LEVEL;
      param_write_accept <= ifd_pkg::IFD_RST_LEVEL;
      param_write_reject <= ifd_pkg::IFD_RST_LEVEL;
    end
    else
    begin
      settle <= next_settle;
      ext_prev <= next_ext_prev;
      ack_prev <= next_ack_prev;
      prun_prev <= next_prun_prev;
      three_wire_run <= next_three_wire_run;
      three_wire_ccw <= next_three_wire_ccw;
      cmd_run_cw <= next_cmd_run_cw;
      cmd_run_ccw <= next_cmd_run_ccw;
      cmd_ramp_stop <= next_cmd_ramp_stop;
      cmd_coast <= next_cmd_coast;
      preset_speed_select <= next_preset_speed_select;
      setpoint_source <= next_setpoint_source;
      cmd_jog <= next_cmd_jog;
      cmd_jog_stop_mode <= next_cmd_jog_stop_mode;
      dc_brake_enable <= next_dc_brake_enable;
      second_param_set <= next_second_param_set;
      alternate_ramp <= next_alternate_ramp;
      heavy_start_mode <= next_heavy_start_mode;
      fault_e12 <= next_fault_e12;
      fault_clear <= next_fault_clear;
      restart_blocked <= next_restart_blocked;
      param_write_accept <= next_param_write_accept;
      param_write_reject <= next_param_write_reject;
    end
  end

  sequence s_ext_edge;
    act_ext && !ext_prev && armed;
  endsequence

  sequence s_recovery;
    mains_recovered && act_lock && start_req;
  endsequence

  property p_both_dir_stop;
    @(posedge sys_clk) disable iff (!nrst)
    (!has_three_wire && cw_level && act_ccw) |=>
      (!cmd_run_cw && !cmd_run_ccw);
  endproperty
  a_both_dir_stop: assert property (p_both_dir_stop)
    else $error("run issued with both directions closed");

  property p_ccw_run;
    @(posedge sys_clk) disable iff (!nrst)
    (!has_three_wire && act_ccw && !cw_level && !inhibit) |=> cmd_run_ccw;
  endproperty
  a_ccw_run: assert property (p_ccw_run)
    else $error("anticlockwise run not issued");

  property p_fault_latch;
    @(posedge sys_clk) disable iff (!nrst)
    s_ext_edge |=> fault_e12 ##1
      (fault_e12 || $past(act_ack && !ack_prev && armed));
  endproperty
  a_fault_latch: assert property (p_fault_latch)
    else $error("outside fault not latched");

  property p_fault_motor_off;
    @(posedge sys_clk) disable iff (!nrst)
    fault_e12 |=> !cmd_run_cw && !cmd_run_ccw && cmd_coast;
  endproperty
  a_fault_motor_off: assert property (p_fault_motor_off)
    else $error("motor driven during latched fault");

  property p_coast;
    @(posedge sys_clk) disable iff (!nrst)
    act_coast |=> cmd_coast && !cmd_run_cw && !cmd_run_ccw && !cmd_ramp_stop;
  endproperty
  a_coast: assert property (p_coast)
    else $error("coast input did not remove drive");

  property p_restart_block;
    @(posedge sys_clk) disable iff (!nrst)
    s_recovery |=> restart_blocked ##1 (!cmd_run_cw && !cmd_run_ccw);
  endproperty
  a_restart_block: assert property (p_restart_block)
    else $error("restart after mains recovery not blocked");

  property p_write_lock;
    @(posedge sys_clk) disable iff (!nrst)
    (param_write_req && act_wlock) |=>
      param_write_reject && !param_write_accept;
  endproperty
  a_write_lock: assert property (p_write_lock)
    else $error("protected write not rejected");

  property p_ack_running;
    @(posedge sys_clk) disable iff (!nrst)
    (act_ack && motor_running) |=> cmd_coast && !cmd_run_cw && !cmd_run_ccw;
  endproperty
  a_ack_running: assert property (p_ack_running)
    else $error("acknowledge while running did not coast");

  property p_analog_source;
    @(posedge sys_clk) disable iff (!nrst)
    (!act_jog && preset_bits == 4'h0) |=>
      (setpoint_source == ifd_pkg::IFD_SRC_CURRENT) == $past(act_cur);
  endproperty
  a_analog_source: assert property (p_analog_source)
    else $error("wrong analog setpoint source");

  property p_dc_brake;
    @(posedge sys_clk) disable iff (!nrst)
    !act_db |=> !dc_brake_enable;
  endproperty
  a_dc_brake: assert property (p_dc_brake)
    else $error("DC brake enabled with input inactive");

endmodule : ifd_decoder

/* File: ifd_pkg.sv */
// Function codes, reset values and shared types of the input decoder
package ifd_pkg;

  localparam int unsigned IFD_NUM_INPUTS = 5;
  localparam int unsigned IFD_CODE_W = 8;
  localparam int unsigned IFD_SYNC_STAGES = 2;
  localparam int unsigned IFD_PRESET_BITS = 4;

  localparam logic [7:0] IFD_CODE_CCW_RUN = 8'h01;
  localparam logic [7:0] IFD_CODE_PRESET0 = 8'h02;
  localparam logic [7:0] IFD_CODE_PRESET1 = 8'h03;
  localparam logic [7:0] IFD_CODE_PRESET2 = 8'h04;
  localparam logic [7:0] IFD_CODE_PRESET3 = 8'h05;
  localparam logic [7:0] IFD_CODE_JOG = 8'h06;
  localparam logic [7:0] IFD_CODE_DC_BRAKE = 8'h07;
  localparam logic [7:0] IFD_CODE_SECOND_SET = 8'h08;
  localparam logic [7:0] IFD_CODE_ALT_RAMP = 8'h09;
  localparam logic [7:0] IFD_CODE_COAST = 8'h11;
  localparam logic [7:0] IFD_CODE_EXT_FAULT = 8'h12;
  localparam logic [7:0] IFD_CODE_RESTART_LOCK = 8'h13;
  localparam logic [7:0] IFD_CODE_HEAVY_START = 8'h14;
  localparam logic [7:0] IFD_CODE_WRITE_LOCK = 8'h15;
  localparam logic [7:0] IFD_CODE_CURRENT_SEL = 8'h16;
  localparam logic [7:0] IFD_CODE_FAULT_ACK = 8'h18;
  localparam logic [7:0] IFD_CODE_PULSE_RUN = 8'h20;
  localparam logic [7:0] IFD_CODE_PULSE_STOP = 8'h21;
  localparam logic [7:0] IFD_CODE_DIR_SELECT = 8'h22;

  localparam logic IFD_RST_LEVEL = 1'b0;
  localparam logic [3:0] IFD_RST_PRESET = 4'h0;
  localparam logic [1:0] IFD_RST_JOG_MODE = 2'h0;

  typedef enum logic [1:0] {
    IFD_SRC_VOLTAGE,
    IFD_SRC_CURRENT,
    IFD_SRC_PRESET,
    IFD_SRC_JOG
  } ifd_src_t;

endpackage : ifd_pkg

/* File: ifd_sync.sv */
// Two-stage synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ns
module ifd_sync #(
  parameter int unsigned WIDTH = 6
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // First stage is read only by the second stage
  always_comb
  begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule : ifd_sync

/* File: ifd_switches.sv */
// Behavioural model of the operator switches on the input terminals
`timescale 1ns/1ns
module ifd_switches (
  input wire logic [4:0] want_pin,
  input wire logic want_cw,
  output logic [4:0] prog_input_pin,
  output logic clockwise_run_input
);
  // Contacts move unrelated to the clock, so they lag the bench edge
  assign #3 prog_input_pin = want_pin;
  assign #3 clockwise_run_input = want_cw;
endmodule : ifd_switches

/* File: testbench.sv */
// Self-checking bench for the input function decoder
`timescale 1ns/1ns
module testbench;
  logic sys_clk, nrst, want_cw, clockwise_run_input;
  logic [4:0] want_pin, prog_input_pin, nc_polarity;
  logic [39:0] func_code;
  logic [1:0] jog_stop_mode, cmd_jog_stop_mode;
  logic mains_recovered, motor_running, param_write_req;
  logic cmd_run_cw, cmd_run_ccw, cmd_ramp_stop, cmd_coast, cmd_jog;
  logic [3:0] preset_speed_select;
  ifd_pkg::ifd_src_t setpoint_source;
  logic dc_brake_enable, second_param_set, alternate_ramp, heavy_start_mode;
  logic fault_e12, fault_clear, restart_blocked;
  logic param_write_accept, param_write_reject, acc, rej;
  logic [7:0] lvl [4];
  int n_errors, total_checks;

  ifd_switches u_sw (.want_pin, .want_cw, .prog_input_pin,
    .clockwise_run_input);

  ifd_decoder #(.NUM_INPUTS(5)) u_dut (.sys_clk, .nrst, .prog_input_pin,
    .clockwise_run_input, .func_code, .nc_polarity, .jog_stop_mode,
    .mains_recovered, .motor_running, .param_write_req, .cmd_run_cw,
    .cmd_run_ccw, .cmd_ramp_stop, .cmd_coast, .preset_speed_select,
    .setpoint_source, .cmd_jog, .cmd_jog_stop_mode, .dc_brake_enable,
    .second_param_set, .alternate_ramp, .heavy_start_mode, .fault_e12,
    .fault_clear, .restart_blocked, .param_write_accept,
    .param_write_reject);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task close_out;
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task code(input int i, input logic [7:0] c);
    func_code[8*i +: 8] = c;
  endtask : code

  // Four edges cover two sync stages, a latch flop and the output flop; the lag ends before the first
  task pins(input logic [4:0] p, input logic cw);
    want_pin = p;
    want_cw = cw;
    tick(4);
  endtask : pins

  // Pulse answers stand one cycle, so every cycle of the window is seen
  task write_try;
    param_write_req = 1'b1;
    tick(1);
    param_write_req = 1'b0;
    acc = 1'b0;
    rej = 1'b0;
    repeat (3)
    begin
      acc = acc | param_write_accept;
      rej = rej | param_write_reject;
      tick(1);
    end
  endtask : write_try

  task levels_are(input logic [3:0] exp);
    chk("level_outputs", 8'(exp), 8'({dc_brake_enable, second_param_set,
      alternate_ramp, heavy_start_mode}));
  endtask : levels_are

  initial
  begin
    nrst = 1'b0;
    want_pin = 5'h00;
    want_cw = 1'b0;
    func_code = 40'h00_0000_0000;
    nc_polarity = 5'h00;
    jog_stop_mode = 2'h0;
    mains_recovered = 1'b0;
    motor_running = 1'b0;
    param_write_req = 1'b0;
    lvl = '{8'h07, 8'h08, 8'h09, 8'h14};
    n_errors = 0;
    total_checks = 0;
    tick(2);
    chk("rst_ramp_stop", 8'h01, 8'(cmd_ramp_stop));
    chk("rst_run", 8'h00, 8'({cmd_run_cw, cmd_run_ccw, fault_e12}));
    chk("rst_source", 8'h00, 8'(setpoint_source));
    nrst = 1'b1;
    code(0, 8'h01);
    pins(5'h01, 1'b0);
    chk("ccw_run", 8'h01, 8'({cmd_run_cw, cmd_run_ccw}));
    pins(5'h00, 1'b1);
    chk("cw_run", 8'h01, 8'({cmd_run_ccw, cmd_run_cw}));
    pins(5'h01, 1'b1);
    chk("both_run", 8'h01,
      8'({cmd_run_cw, cmd_run_ccw, cmd_ramp_stop}));
    pins(5'h00, 1'b0);
    chk("open_stop", 8'h01, 8'(cmd_ramp_stop));
    code(1, 8'h02);
    code(2, 8'h03);
    code(3, 8'h04);
    code(4, 8'h05);
    for (int p = 0; p < 16; p++)
    begin
      pins({4'(p), 1'b0}, 1'b0);
      chk("preset", 8'(p),
        8'(preset_speed_select));
      chk("preset_src", (p == 0) ? 8'(ifd_pkg::IFD_SRC_VOLTAGE) :
        8'(ifd_pkg::IFD_SRC_PRESET), 8'(setpoint_source));
    end
    func_code = 40'h00_0000_0000;
    for (int k = 0; k < 4; k++)
    begin
      code(0, lvl[k]);
      pins(5'h01, 1'b0);
      levels_are(4'h8 >> k);
      pins(5'h00, 1'b0);
      levels_are(4'h0);
    end
    nc_polarity = 5'h01;
    code(0, 8'h07);
    pins(5'h00, 1'b0);
    levels_are(4'h8);
    nc_polarity = 5'h00;
    code(0, 8'h16);
    pins(5'h01, 1'b0);
    chk("current_sel", 8'(ifd_pkg::IFD_SRC_CURRENT),
      8'(setpoint_source));
    // Codes in the gaps of the map must leave every command idle
    for (int u = 0; u < 2; u++)
    begin
      func_code = (u == 0) ? 40'h10_1010_1010 : 40'h17_1717_1717;
      pins(5'h1f, 1'b0);
      levels_are(4'h0);
      chk("unk_cmd", 8'h01, 8'({cmd_coast, cmd_jog, fault_e12, cmd_run_cw,
        cmd_run_ccw, cmd_ramp_stop}));
      // No preset bits and voltage source, which is code 0
      chk("unk_src", 8'h00,
        8'({preset_speed_select, setpoint_source}));
    end
    func_code = 40'h00_0000_0011;
    pins(5'h00, 1'b1);
    pins(5'h01, 1'b1);
    chk("coast", 8'h02, 8'({cmd_coast, cmd_run_cw}));
    func_code = 40'h00_0000_1812;
    nc_polarity = 5'h02;
    pins(5'h01, 1'b0);
    pins(5'h00, 1'b0);
    chk("fault_latch", 8'h03, 8'({fault_e12, cmd_coast}));
    // Clear pulse stands one cycle, three edges after the pin
    want_pin = 5'h02;
    tick(3);
    chk("fault_clear", 8'h01, 8'(fault_clear));
    tick(1);
    chk("fault_ack", 8'h00, 8'({fault_e12, fault_clear}));
    pins(5'h00, 1'b0);
    motor_running = 1'b1;
    pins(5'h02, 1'b0);
    chk("ack_running", 8'h01, 8'(cmd_coast));
    motor_running = 1'b0;
    nc_polarity = 5'h00;
    func_code = 40'h00_0000_0013;
    pins(5'h01, 1'b1);
    chk("lock_run", 8'h01, 8'(cmd_run_cw));
    mains_recovered = 1'b1;
    tick(1);
    mains_recovered = 1'b0;
    tick(3);
    chk("lock_block", 8'h02,
      8'({restart_blocked, cmd_run_cw}));
    pins(5'h01, 1'b0);
    chk("lock_free", 8'h00, 8'(restart_blocked));
    func_code = 40'h00_0000_0015;
    pins(5'h00, 1'b0);
    write_try;
    chk("write_open", 8'h02, 8'({acc, rej}));
    pins(5'h01, 1'b0);
    write_try;
    chk("write_lock", 8'h01, 8'({acc, rej}));
    func_code = 40'h00_0000_0006;
    jog_stop_mode = 2'h2;
    pins(5'h01, 1'b1);
    chk("jog", 8'h01, 8'(cmd_jog));
    chk("jog_src", 8'(ifd_pkg::IFD_SRC_JOG),
      8'(setpoint_source));
    chk("jog_stop", 8'h02, 8'(cmd_jog_stop_mode));
    func_code = 40'h00_0022_2120;
    pins(5'h02, 1'b0);
    pins(5'h03, 1'b0);
    pins(5'h02, 1'b0);
    chk("pulse_run", 8'h02, 8'({cmd_run_cw, cmd_run_ccw}));
    pins(5'h06, 1'b0);
    chk("pulse_dir", 8'h01, 8'({cmd_run_cw, cmd_run_ccw}));
    pins(5'h04, 1'b0);
    chk("pulse_stop", 8'h01,
      8'({cmd_run_cw, cmd_run_ccw, cmd_ramp_stop}));
    // Closed break contact on the fault input must not latch across reset
    func_code = 40'h00_0000_0012;
    nc_polarity = 5'h01;
    pins(5'h01, 1'b0);
    nrst = 1'b0;
    tick(2);
    chk("rst2_out", 8'h01, 8'({fault_e12, cmd_run_cw, cmd_ramp_stop}));
    nrst = 1'b1;
    pins(5'h01, 1'b0);
    chk("rst2_fault", 8'h00, 8'(fault_e12));
    close_out;
  end
endmodule : testbench
